// [hw/dtlt_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// - counter one starts at zero after reset, counts at osc/32, hidden from software
// - counter one overflows on wrap from f9h to 00h
// - period double select makes counter one overflow every second wrap
// - counter one overflow sets timebase one flag; irq when flag and enable
// - reading control/status one clears timebase one flag
// - capture pin edge latches counter one and sets capture flag
// - capture value holds last capture until the next one
// - capture edges ignored while capture flag is set
// - reading capture value clears flag; irq when flag and enable
// - counter two starts from reload value, counts at osc/32, readable
// - counter two reloads from reload value after passing ffh
// - reload writes take effect only at next counter two overflow
// - counter two period programmable in 256 steps of one prescaled tick
// - counter two overflow sets timebase two flag; irq when flag and enable
// - reading control/status two clears timebase two flag
// - slow, wait and active halt do not affect the timer
// - halt stops both counters
// - three separate interrupt lines, each gated by its own enable
// - software cannot write the timebase flags
module dtlt_timer (
  input  wire logic       clk_in,                    // oscillator clock
  input  wire logic       resetn_in,                 // async reset, active low
  input  wire logic       halt_in,                   // halt mode, stops counting
  input  wire logic       capture_input_pin_in,      // external capture pin
  input  wire logic       period_double_select_in,   // doubles counter one period
  input  wire logic       timebase_one_irq_enable_in,// enable for timebase one irq
  input  wire logic       timebase_two_irq_enable_in,// enable for timebase two irq
  input  wire logic       capture_irq_enable_in,     // enable for capture irq
  input  wire logic       reload_write_in,           // strobe: write reload value
  input  wire logic [7:0] reload_wdata_in,           // reload data
  input  wire logic       ctrl_status_one_read_in,   // strobe: read control/status one
  input  wire logic       ctrl_status_two_read_in,   // strobe: read control/status two
  input  wire logic       capture_read_in,           // strobe: read capture value
  output logic      [7:0] timer_ctrl_status_one_out, // status byte one
  output logic      [7:0] timer_ctrl_status_two_out, // status byte two
  output logic      [7:0] capture_value_reg_out,     // last captured count
  output logic      [7:0] reload_value_reg_out,      // stored reload value
  output logic      [7:0] second_counter_value_out,  // counter two value
  output logic            timebase_one_flag_out,     // flag, registered
  output logic            timebase_two_flag_out,     // flag, registered
  output logic            capture_flag_out,          // flag, registered
  output logic            timebase_one_irq_out,      // level irq request
  output logic            timebase_two_irq_out,      // level irq request
  output logic            capture_irq_out            // level irq request
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [4:0] prescale;
    logic [7:0] cnt1;
    logic       half;
    logic [7:0] cnt2;
    logic       cnt2_loaded;
    logic [7:0] reload;
    logic [7:0] capture;
    logic       pin_last;
    logic       tb1_flag;
    logic       tb2_flag;
    logic       cap_flag;
  } dtlt_state_t;

  dtlt_state_t state;
  dtlt_state_t next_state;

  logic pin_sync;

  // pin crosses in through two flops before edge detection
  dtlt_sync u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (capture_input_pin_in),
    .sync_out  (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // increment with wrap at a top value
  function automatic logic [7:0] dtlt_wrap_inc(input logic [7:0] value, input logic [7:0] top);
    dtlt_wrap_inc = (value == top) ? 8'h00 : 8'(value + 8'h01);
  endfunction

  // flag update: a set in the clearing cycle wins
  function automatic logic dtlt_flag(input logic flag, input logic set, input logic clr);
    dtlt_flag = set | (flag & ~clr);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic tick;
  logic ovf1;
  logic evt1;
  logic ovf2;
  logic edge_seen;
  logic cap_take;

  always_comb begin
    next_state = state;
    // prescaler runs from the oscillator only; low power clock gating is
    // outside this block, so slow/wait/active halt change nothing
    tick = 1'b0;
    if (!halt_in) begin
      next_state.prescale = 5'(state.prescale + 5'h01);
      tick = (state.prescale == dtlt_pkg::PRESCALE_MAX);
    end

    // counter one: hidden free runner, 250 ticks per wrap
    ovf1 = tick && (state.cnt1 == dtlt_pkg::CNT1_TOP);
    if (tick) begin
      next_state.cnt1 = dtlt_wrap_inc(state.cnt1, dtlt_pkg::CNT1_TOP);
    end
    // doubled period: only every second wrap counts as an event
    evt1 = ovf1 && (!period_double_select_in || state.half);
    if (ovf1) begin
      next_state.half = period_double_select_in ? ~state.half : 1'b0;
    end

    // counter two: first tick after reset loads the reload value
    ovf2 = tick && state.cnt2_loaded && (state.cnt2 == dtlt_pkg::CNT2_TOP);
    if (tick) begin
      next_state.cnt2_loaded = 1'b1;
      if (!state.cnt2_loaded || ovf2) begin
        next_state.cnt2 = state.reload;
      end else begin
        next_state.cnt2 = 8'(state.cnt2 + 8'h01);
      end
    end
    // writes land in the reload register only, counter sees them at overflow
    if (reload_write_in) begin
      next_state.reload = reload_wdata_in;
    end

    // capture: any edge of the synchronised pin, blocked while flag set
    next_state.pin_last = pin_sync;
    edge_seen = (pin_sync != state.pin_last);
    cap_take  = edge_seen && !state.cap_flag;
    if (cap_take) begin
      next_state.capture = state.cnt1;
    end

    // flags: set by hardware, cleared only by reads, never by writes
    next_state.tb1_flag = dtlt_flag(state.tb1_flag, evt1, ctrl_status_one_read_in);
    next_state.tb2_flag = dtlt_flag(state.tb2_flag, ovf2, ctrl_status_two_read_in);
    next_state.cap_flag = dtlt_flag(state.cap_flag, cap_take, capture_read_in);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // capture flag resets to zero here; software still reads once after
  // reset, which is harmless
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state          <= '0;
      state.cnt1     <= dtlt_pkg::CNT1_RESET;
      state.reload   <= dtlt_pkg::RELOAD_RESET;
      state.capture  <= dtlt_pkg::CAPTURE_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // status bytes, reserved bits read zero
  always_comb begin
    timer_ctrl_status_one_out = 8'h00;
    timer_ctrl_status_one_out[dtlt_pkg::CS1_CAP_IE_POS] = capture_irq_enable_in;
    timer_ctrl_status_one_out[dtlt_pkg::CS1_CAP_F_POS]  = state.cap_flag;
    timer_ctrl_status_one_out[dtlt_pkg::CS1_DBL_POS]    = period_double_select_in;
    timer_ctrl_status_one_out[dtlt_pkg::CS1_TB1_IE_POS] = timebase_one_irq_enable_in;
    timer_ctrl_status_one_out[dtlt_pkg::CS1_TB1_F_POS]  = state.tb1_flag;
    timer_ctrl_status_two_out = 8'h00;
    timer_ctrl_status_two_out[dtlt_pkg::CS2_TB2_IE_POS] = timebase_two_irq_enable_in;
    timer_ctrl_status_two_out[dtlt_pkg::CS2_TB2_F_POS]  = state.tb2_flag;
  end

  assign capture_value_reg_out    = state.capture;
  assign reload_value_reg_out     = state.reload;
  assign second_counter_value_out = state.cnt2;
  assign timebase_one_flag_out    = state.tb1_flag;
  assign timebase_two_flag_out    = state.tb2_flag;
  assign capture_flag_out         = state.cap_flag;

  // level requests, one line each
  assign timebase_one_irq_out = state.tb1_flag & timebase_one_irq_enable_in;
  assign timebase_two_irq_out = state.tb2_flag & timebase_two_irq_enable_in;
  assign capture_irq_out      = state.cap_flag & capture_irq_enable_in;

endmodule // dtlt_timer

`default_nettype wire

// [hw/dtlt_pkg.sv]
package dtlt_pkg;

  // oscillator divide ratio feeding both counters
  localparam int unsigned PRESCALE_DIV = 32;
  localparam logic [4:0]  PRESCALE_MAX = 5'h1f;

  // counter one wraps after this value
  localparam logic [7:0] CNT1_TOP   = 8'hf9;
  localparam logic [7:0] CNT1_RESET = 8'h00;

  // counter two overflows past this value
  localparam logic [7:0] CNT2_TOP = 8'hff;

  // reset values of the software visible fields
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  localparam logic [7:0] CAPTURE_RESET = 8'h00;

  // status byte layout of control/status one
  localparam int unsigned CS1_CAP_IE_POS = 7;
  localparam int unsigned CS1_CAP_F_POS  = 6;
  localparam int unsigned CS1_DBL_POS    = 5;
  localparam int unsigned CS1_TB1_IE_POS = 4;
  localparam int unsigned CS1_TB1_F_POS  = 3;

  // status byte layout of control/status two
  localparam int unsigned CS2_TB2_IE_POS = 1;
  localparam int unsigned CS2_TB2_F_POS  = 0;

endpackage : dtlt_pkg

// [hw/dtlt_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two flop synchroniser for the capture pin
module dtlt_sync (
  input  wire logic clk_in,     // system clock
  input  wire logic resetn_in,  // async reset, active low
  input  wire logic async_in,   // raw pin level
  output logic      sync_out    // level in clk_in domain
);

  typedef struct packed {
    logic meta;
    logic stable;
  } dtlt_sync_state_t;

  dtlt_sync_state_t state;
  dtlt_sync_state_t next_state;

  // first stage feeds only the second
  always_comb begin
    next_state.meta   = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule // dtlt_sync

`default_nettype wire

// [testbench/dtlt_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
// far side source: flips the capture pin shortly after a request edge
module dtlt_pin_src (
  input  wire logic clk_in,    // bench clock
  input  wire logic toggle_in, // flip request
  input  wire logic slow_in,   // late flip, still inside the cycle
  output logic      pin_out    // capture pin level
);
  // pin moves off the edge, as an unsynchronised source would
  initial pin_out = 1'b0;
  always @(posedge clk_in)
    if (toggle_in)
      pin_out <= #(slow_in ? 40 : 7) ~pin_out;
endmodule // dtlt_pin_src
`default_nettype wire

// [testbench/dtlt_timer_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the timer ports; grouped ports keep the checker small
module dtlt_timer_sva (
  input wire logic       clk_in, resetn_in, halt_in, reload_write_in,            // clock, reset, controls
  input wire logic       timebase_one_irq_enable_in, timebase_two_irq_enable_in, // enables
  input wire logic       capture_irq_enable_in, capture_read_in,                 // capture controls
  input wire logic       ctrl_status_one_read_in, ctrl_status_two_read_in,       // read strobes
  input wire logic [7:0] reload_wdata_in, capture_value_reg_out,                 // data
  input wire logic [7:0] reload_value_reg_out, second_counter_value_out,         // registers
  input wire logic       timebase_one_flag_out, timebase_two_flag_out, capture_flag_out, // flags
  input wire logic       timebase_one_irq_out, timebase_two_irq_out, capture_irq_out     // requests
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////
  // counter two leaving its top value must land on the reload value
  sequence s_leave_top;
    $changed(second_counter_value_out) && $past(second_counter_value_out) == 8'hff;
  endsequence
  sequence s_reloaded;
    second_counter_value_out == $past(reload_value_reg_out) && timebase_two_flag_out;
  endsequence
  chk_cnt2_reload: assert property (s_leave_top |-> s_reloaded)
    else $error("counter two did not reload with flag");
  chk_cnt2_spacing: assert property ($changed(second_counter_value_out) |=>
    $stable(second_counter_value_out)[*8]) else $error("counter two stepped too soon");
  chk_halt_freeze: assert property (halt_in |=> $stable(second_counter_value_out))
    else $error("counter two moved in halt");
  chk_reload_store: assert property (reload_write_in |=> reload_value_reg_out == $past(reload_wdata_in))
    else $error("reload value not stored");
  chk_cap_hold: assert property (capture_flag_out |=> $stable(capture_value_reg_out))
    else $error("capture changed while flag set");
  chk_cap_sets: assert property ($changed(capture_value_reg_out) |-> $rose(capture_flag_out))
    else $error("capture without new flag");
  chk_cap_clear: assert property (capture_read_in && capture_flag_out |=> !capture_flag_out)
    else $error("capture flag not cleared");
  chk_tb1_clear: assert property (ctrl_status_one_read_in |=>
    !timebase_one_flag_out || $rose(timebase_one_flag_out)) else $error("flag one not cleared");
  chk_tb2_clear: assert property (ctrl_status_two_read_in && second_counter_value_out != 8'hff |=>
    !timebase_two_flag_out) else $error("flag two not cleared");
  // requests are plain levels of flag and enable
  chk_irq_one: assert property (timebase_one_irq_out == (timebase_one_flag_out && timebase_one_irq_enable_in))
    else $error("request one wrong");
  chk_irq_two: assert property (timebase_two_irq_out == (timebase_two_flag_out && timebase_two_irq_enable_in))
    else $error("request two wrong");
  chk_irq_cap: assert property (capture_irq_out == (capture_flag_out && capture_irq_enable_in))
    else $error("capture request wrong");
endmodule // dtlt_timer_sva
bind dtlt_timer dtlt_timer_sva i_dtlt_timer_sva (.*);
`default_nettype wire

// [testbench/dtlt_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dtlt_timer_tb;
  logic       clk_in = 0, resetn = 0, halt = 0, dbl = 0, ie1 = 0, ie2 = 0, iec = 0;
  logic       tog = 0, slow = 0, wr = 0, rd1 = 0, rd2 = 0, rdc = 0;
  logic [7:0] wdata = 0, r0, r1;
  logic [2:0] fl_q = 0;
  wire  [7:0] cs1, cs2, cnt2, capv, rld;
  wire  [2:0] fl;
  wire        pin;
  int         mismatches = 0, checked = 0, cyc = 0, t0;
  logic [7:0] exp_cap[$], exp_cnt[$];
  ////////////////////////////////////////////////////////////
  // clock; cyc mirrors the prescaler, so halted edges are skipped
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (resetn && !halt) cyc <= cyc + 1;
  dtlt_timer i_dtlt_timer (.clk_in(clk_in), .resetn_in(resetn), .halt_in(halt), .capture_input_pin_in(pin),
    .period_double_select_in(dbl), .timebase_one_irq_enable_in(ie1), .timebase_two_irq_enable_in(ie2),
    .capture_irq_enable_in(iec), .reload_write_in(wr), .reload_wdata_in(wdata), .ctrl_status_one_read_in(rd1),
    .ctrl_status_two_read_in(rd2), .capture_read_in(rdc), .timer_ctrl_status_one_out(cs1),
    .timer_ctrl_status_two_out(cs2), .capture_value_reg_out(capv), .reload_value_reg_out(rld),
    .second_counter_value_out(cnt2), .timebase_one_flag_out(fl[0]), .timebase_two_flag_out(fl[1]),
    .capture_flag_out(fl[2]), .timebase_one_irq_out(), .timebase_two_irq_out(), .capture_irq_out());
  dtlt_pin_src i_dtlt_pin_src (.clk_in(clk_in), .toggle_in(tog), .slow_in(slow), .pin_out(pin));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one-cycle strobe: 0 reload write, 1 read one, 2 read two, 3 read capture
  task automatic strobe(input int k);
    {wr, rd1, rd2, rdc} = 4'b1000 >> k;
    @(negedge clk_in);
    {wr, rd1, rd2, rdc} = 4'h0;
  endtask
  // bounded wait for a flag to rise; a timeout ends the run
  task automatic wait_rise(input int b);
    logic p;
    p = fl[b];
    for (int i = 0; i < 20000; i++) begin
      @(negedge clk_in);
      if (fl[b] && !p) return;
      p = fl[b];
    end
    mismatches++;
    report_and_stop();
  endtask
  // scoreboard: each rising capture or timebase two flag takes the oldest note
  always @(negedge clk_in) begin
    if (fl[2] && !fl_q[2]) cmp("capture", exp_cap.pop_front(), capv);
    if (fl[1] && !fl_q[1]) cmp("cnt2 reload", exp_cnt.pop_front(), cnt2);
    fl_q = fl;
  end
  ////////////////////////////////////////////////////////////
  // main sequence, inputs move on the falling edge
  initial begin
    void'($urandom(9));
    r0 = 8'h80 + 8'($urandom_range(126)); // short periods, never ff
    r1 = 8'h80 + 8'($urandom_range(126));
    {ie1, ie2, iec} = 3'($urandom);
    repeat (12) @(negedge clk_in);
    resetn = 1;
    wdata = r0;
    strobe(0);
    exp_cnt = '{r0, r0};
    cmp("reload", r0, rld);
    cmp("cnt2 at reset", 8'h00, cnt2);
    strobe(3);
    // capture, ignored capture while flag set, capture again
    for (int k = 0; k < 3; k++) begin
      while (cyc % 32 != 13) @(negedge clk_in);
      if (k != 1) exp_cap.push_back(8'(((cyc + 3) / 32) % 250));
      slow = k[0];
      tog = 1;
      @(negedge clk_in);
      tog = 0;
      repeat (40) @(negedge clk_in);
      if (k == 1) begin
        cmp("cs1", {iec, 1'b1, dbl, ie1, fl[0], 3'h0}, cs1);
        strobe(3);
        cmp("cap flag", 0, fl[2]);
      end
    end
    wait_rise(0);
    cmp("tb1 first", 16'd8000, 16'(cyc));
    strobe(1);
    strobe(2);
    // new reload must wait for the overflow; halt must not shorten
    wait_rise(1);
    t0 = cyc;
    wdata = r1;
    exp_cnt.push_back(r1);
    strobe(0);
    strobe(2);
    cmp("cs2", {6'h00, ie2, 1'b0}, cs2);
    halt = 1;
    repeat (50) @(negedge clk_in);
    halt = 0;
    wait_rise(1);
    cmp("tb2 period", 16'((256 - r0) * 32), 16'(cyc - t0));
    dbl = 1;
    strobe(1);
    wait_rise(0);
    t0 = cyc;
    strobe(1);
    wait_rise(0);
    cmp("tb1 doubled", 16'd16000, 16'(cyc - t0));
    report_and_stop();
  end
endmodule // dtlt_timer_tb
`default_nettype wire
